// [dv/fmc_flash_model.sv]
// Behavioural dual-bank flash that answers the host controller's pins.
// Assumes pins move just after clk_sys edges; the array is 256 words deep.
`timescale 1ns/1ps
module fmc_flash_model import fmc_pkg::*; #(
    parameter int          PROG_CYC    = 8,
    parameter logic [15:0] MAKER_CODE  = 16'h00a5, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5a3c  // Arbitrary value
) (
    input  wire logic        clk_sys,
    input  wire logic [21:0] flash_addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        flash_chip_select_n,
    input  wire logic        write_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        flash_reset_n,
    input  wire logic        stall,
    output logic      [15:0] dq_in,
    output logic             ready_busy_n
);
    logic [15:0] mem [0:255];
    logic [15:0] last     = 16'h0;
    logic [21:0] lat_addr = 22'h0;
    logic [6:0]  id_bank  = 7'h0;
    logic        we_q     = 1'b1;
    logic        id_mode  = 1'b0;
    logic        fast     = 1'b0;
    int          step     = 0;
    int          busy_cnt = 0;
    logic [7:0]  cmd;
    logic [15:0] rd;
    logic        drive;

    initial foreach (mem[i]) mem[i] = 16'hffff;
    assign cmd = dq_out[7:0];
    assign ready_busy_n = (busy_cnt == 0);
    assign rd = (id_mode && flash_addr[21:15] == id_bank && flash_addr[14:1] == 14'h0) ?
                (flash_addr[0] ? DEVICE_CODE : MAKER_CODE) : mem[flash_addr[7:0]];
    assign drive = !flash_chip_select_n && !output_enable_n && flash_reset_n;
    // Nothing pulls the lines, so a released bus shows the inverse of the last value
    assign dq_in = drive ? rd : ~last;

    always @(posedge clk_sys) begin
        we_q <= write_enable_n;
        if (drive)
            last <= rd;
        if (busy_cnt > 0 && !stall)
            busy_cnt <= busy_cnt - 1;
        if (!flash_reset_n) begin
            step     <= 0;
            id_mode  <= 1'b0;
            fast     <= 1'b0;
            busy_cnt <= 0;
        end else if (!write_enable_n && we_q && !flash_chip_select_n) begin
            lat_addr <= flash_addr;
        end else if (write_enable_n && !we_q && !flash_chip_select_n && busy_cnt == 0) begin
            step <= 0;
            case (step)
                0: if (cmd == CMD_RESET) id_mode <= 1'b0;
                   else if (cmd == CMD_UNLOCK1) step <= 1;
                   else if (fast && cmd == CMD_PROG) step <= 3;
                   else if (fast && cmd == CMD_FAST_EXIT) step <= 4;
                1: if (cmd == CMD_UNLOCK2) step <= 2;
                2: if (cmd == CMD_PROG) step <= 3;
                   else if (cmd == CMD_IDREAD) begin
                       id_mode <= 1'b1;
                       id_bank <= lat_addr[21:15];
                   end else if (cmd == CMD_FAST) fast <= 1'b1;
                3: begin
                    if (|lat_addr[7:0])
                        mem[lat_addr[7:0]] <= mem[lat_addr[7:0]] & dq_out;
                    busy_cnt           <= PROG_CYC;
                end
                default: if (cmd == CMD_RESET) fast <= 1'b0;
            endcase
        end
    end
endmodule : fmc_flash_model

// [dv/test_fmc_host.sv]
// Self-checking bench driving the flash host controller through its registers.
// Assumes the register map and op codes of fmc_pkg and the flash model beside it.
`timescale 1ns/1ps
module test_fmc_host import fmc_pkg::*;;
    localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
    localparam logic [15:0] DEVID = 16'h5a3c; // Arbitrary value
    logic        clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [21:0] flash_addr;
    logic [15:0] dq_out, dq_in, d1, d2, d3;
    logic        byte_lsb_address, dq_oe, flash_chip_select_n, write_enable_n;
    logic        output_enable_n, flash_reset_n, flash_width_select, ready_busy_n;
    logic        want = 1'b0, want_d = 1'b0;
    logic [21:0] a1;
    logic [31:0] exp_q[$];
    int          error_cnt = 0, num_checks = 0, cyc = 0, n;

    fmc_host #(.PROG_TIMEOUT_CYC(50)) fmc_host_inst (.clk_sys(clk_sys), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr), .byte_lsb_address(byte_lsb_address),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .flash_chip_select_n(flash_chip_select_n),
        .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
        .flash_reset_n(flash_reset_n), .flash_width_select(flash_width_select),
        .ready_busy_n(ready_busy_n));
    fmc_flash_model #(.PROG_CYC(8), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVID))
        fmc_flash_model_inst (.clk_sys(clk_sys), .flash_addr(flash_addr), .dq_out(dq_out),
        .flash_chip_select_n(flash_chip_select_n), .write_enable_n(write_enable_n),
        .output_enable_n(output_enable_n), .flash_reset_n(flash_reset_n), .stall(stall),
        .dq_in(dq_in), .ready_busy_n(ready_busy_n));

    always #25 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Monitor: read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        want_d <= want;
        cyc++;
        if (want_d) check("reg_rdata", exp_q.pop_front(), reg_rdata);
        if (!output_enable_n) check("dq_oe while reading", 32'h0, {31'h0, dq_oe});
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end
    always @(negedge write_enable_n) check("cs_n oe_n at write", 32'h1,
        {30'h0, flash_chip_select_n, output_enable_n});

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        want     <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        want     <= 1'b0;
    endtask : rd

    task automatic wait_idle();
        logic [31:0] v;
        v = 32'h1;
        for (int i = 0; i < 1000 && v[ST_BUSY] !== 1'b0; i++) begin
            @(posedge clk_sys);
            reg_addr <= REG_STATUS;
            reg_rd   <= 1'b1;
            @(posedge clk_sys);
            reg_rd   <= 1'b0;
            @(negedge clk_sys);
            v = reg_rdata;
        end
    endtask : wait_idle

    task automatic run_op(input logic [31:0] op);
        wr(REG_CTRL, 32'h10 | op);
        wait_idle();
    endtask : run_op

    task automatic prog(input logic [21:0] a, input logic [15:0] d);
        wr(REG_ADDR, {10'h0, a});
        wr(REG_WDATA, {16'h0, d});
        run_op(32'h2);
    endtask : prog

    task automatic rd_arr(input logic [21:0] a, input logic [15:0] e);
        wr(REG_ADDR, {10'h0, a});
        run_op(32'h1);
        rd(REG_RDATA, {16'h0, e});
    endtask : rd_arr

    initial begin
        void'($urandom(94));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        check("idle pins", 32'h1f, {27'h0, flash_chip_select_n, write_enable_n,
            output_enable_n, flash_reset_n, flash_width_select});
        rd(REG_STATUS, 32'h18);
        rd(4'hf, 32'h0);
        a1 = {14'h0, 8'($urandom) | 8'h10};
        d1 = 16'($urandom);
        d2 = 16'($urandom);
        d3 = 16'($urandom);
        prog(a1, d1);
        rd_arr(a1, d1);
        prog(a1, d2);
        rd_arr(a1, d1 & d2);
        wr(REG_ADDR, 32'h8000);
        run_op(32'h3);
        rd_arr(22'h008000, MAKER);
        rd_arr(22'h008001, DEVID);
        rd_arr(a1, d1 & d2);
        run_op(32'h4);
        prog(22'h008000, 16'h0);
        rd_arr(22'h008000, 16'hffff);
        run_op(32'h5);
        rd(REG_STATUS, 32'h1a);
        prog(a1 ^ 22'h40, d3);
        rd_arr(a1 ^ 22'h40, d3);
        run_op(32'h6);
        rd(REG_STATUS, 32'h18);
        wr(REG_CTRL, 32'h0);
        @(negedge clk_sys);
        check("width select", 32'h0, {31'h0, flash_width_select});
        rd(REG_STATUS, 32'h08);
        wr(REG_ADDR, {9'h1, a1});
        wr(REG_CTRL, 32'h1);
        wait_idle();
        check("byte lsb", 32'h1, {31'h0, byte_lsb_address});
        rd(REG_RDATA, {24'h0, d1[7:0] & d2[7:0]});
        wr(REG_CTRL, 32'h10);
        stall <= 1'b1;
        prog(22'h000020, 16'h0);
        rd(REG_STATUS, 32'h14);
        wr(REG_STATUS, 32'h4);
        rd(REG_STATUS, 32'h10);
        wr(REG_CTRL, 32'h17);
        n = 0;
        repeat (30) @(negedge clk_sys) if (flash_reset_n === 1'b0) n++;
        check("reset pulse cycles", 32'd10, 32'(n));
        stall <= 1'b0;
        wait_idle();
        rd(REG_STATUS, 32'h18);
        repeat (4) @(posedge clk_sys);
        end_of_test();
    end
endmodule : test_fmc_host

// [rtl/fmc_host.sv]
// Host controller driving a dual-bank flash through its strobe pins.
// Assumes a plain register port and pins sampled synchronously to clk_sys.
//
// Overview of operation
// [R01] Other banks keep serving array reads while one bank is busy.
// [R02] Device returns to read mode at power-on and after automatic operations.
// [R03] First read after power-on needs chip select falling or a hardware reset.
// [R04] Identifier command carries bank address in third cycle; codes at offsets 00, 01.
// [R05] Chip select and reset high in read mode give standby unless bank busy.
// [R06] Reset held low forces standby, aborts operations, floats data pins.
// [R07] Address held 150 ns gives sleep with output data kept.
// [R08] Output enable high floats the device data pins.
// [R09] Commands written by write strobe with chip select low, output enable high.
// [R10] Address latched on falling, data on rising edge of later strobe.
// [R11] Command data on the low eight lines only.
// [R12] Reset or undefined command clears the sequence and returns to read.
// [R13] Software reset leaves identifier mode, releases lock, clears command register.
// [R14] Software reset never stops a running operation; hardware reset does.
// [R15] Hardware reset abandons operation and reaches read mode after ready delay.
// [R16] Width select high uses sixteen lines; low uses eight plus byte address.
// [R17] Fourth program cycle latches address and data, then starts programming.
// [R18] Busy bank refuses command sequences; hardware reset aborts programming.
// [R19] Program to protected block is ignored; read mode after 3 us.
// [R20] Failed program stays in programming state until a reset.
// [R21] Programming only clears bits; setting a zero bit fails.
// [R22] Fast program mode needs two cycles per program until the exit command.
// [R23] Reset held low at least 500 ns; read mode within 20 us.
// [R24] Ready/busy output low while program or erase runs.
`timescale 1ns/1ps
module fmc_host import fmc_pkg::*; #(
    parameter int PROG_TIMEOUT_CYC = PROG_MAX_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [21:0] flash_addr,
    output logic             byte_lsb_address,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    input  wire logic [15:0] dq_in,
    output logic             flash_chip_select_n,
    output logic             write_enable_n,
    output logic             output_enable_n,
    output logic             flash_reset_n,
    output logic             flash_width_select,
    input  wire logic        ready_busy_n
);
    typedef enum logic [3:0] {
        S_IDLE, S_W_SETUP, S_W_LOW, S_W_HOLD, S_R_ACC, S_R_END,
        S_BUSY, S_RST_LOW, S_RST_WAIT
    } fmc_state_t;

    localparam int PW = $clog2(PROG_TIMEOUT_CYC + 1);

    fmc_state_t        state, next_state;
    fmc_op_t           op;
    logic [1:0]        idx;
    logic [22:0]       addr_reg;
    logic [15:0]       wdata_reg;
    logic [15:0]       rdata_reg;
    logic              fast_mode;
    logic              timeout;
    logic              cmd_cycle;
    logic [PW-1:0]     poll_cnt;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_val;
    logic              tmr_done;
    logic              start;
    logic              last_step;
    logic [37:0]       step;
    fmc_op_t           start_op;

    function automatic logic [1:0] fmc_seq_len(input fmc_op_t o, input logic fast);
        case (o)
            OP_PROG:      fmc_seq_len = fast ? 2'd1 : 2'd3;
            OP_IDREAD:    fmc_seq_len = 2'd2;
            OP_FASTENTER: fmc_seq_len = 2'd2;
            OP_FASTEXIT:  fmc_seq_len = 2'd1;
            default:      fmc_seq_len = 2'd0;
        endcase
    endfunction : fmc_seq_len

    // Returns {address, data} of one bus write of a command sequence
    function automatic logic [37:0] fmc_seq_step(input fmc_op_t o, input logic [1:0] i,
                                                 input logic fast, input logic [21:0] a,
                                                 input logic [15:0] d);
        logic [1:0] e;
        e = (fast && o == OP_PROG) ? i + 2'd2 : i; // R22
        fmc_seq_step = (e == 2'd1) ? {ADDR_UNLOCK2, 8'h00, CMD_UNLOCK2}
                                   : {ADDR_UNLOCK1, 8'h00, CMD_UNLOCK1};
        case (o)
            OP_PROG: begin
                if (e == 2'd2) fmc_seq_step = {ADDR_UNLOCK1, 8'h00, CMD_PROG};
                if (e == 2'd3) fmc_seq_step = {a, d}; // R17
            end
            OP_IDREAD: begin
                if (e == 2'd2)
                    fmc_seq_step = {a[21:BANK_LSB], ADDR_UNLOCK1[BANK_LSB-1:0],
                                    8'h00, CMD_IDREAD}; // R04
            end
            OP_FASTENTER: begin
                if (e == 2'd2) fmc_seq_step = {ADDR_UNLOCK1, 8'h00, CMD_FAST}; // R22
            end
            OP_SWRESET:  fmc_seq_step = {ADDR_UNLOCK1, 8'h00, CMD_RESET}; // R13
            OP_FASTEXIT: fmc_seq_step = {ADDR_UNLOCK1, 8'h00,
                                         (e == 2'd0) ? CMD_FAST_EXIT : CMD_RESET}; // R22
            default: ;
        endcase
    endfunction : fmc_seq_step

    assign start     = reg_wr && reg_addr == REG_CTRL && state == S_IDLE;
    assign start_op  = fmc_op_t'(reg_wdata[CTRL_OP_LSB +: 3]);
    assign last_step = (idx == fmc_seq_len(op, fast_mode));
    assign step      = fmc_seq_step(op, idx, fast_mode, addr_reg[21:0], wdata_reg);

    fmc_timer #(.W(TMR_W)) u_timer (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_val    = '0;
        case (state)
            S_IDLE: begin
                if (start) begin
                    tmr_load = 1'b1;
                    case (start_op)
                        OP_NONE: next_state = S_IDLE;
                        OP_READ: begin
                            next_state = S_R_ACC;
                            tmr_val    = TMR_W'(ACC_CYC - 1);
                        end
                        OP_HWRESET: begin
                            next_state = S_RST_LOW;
                            tmr_val    = TMR_W'(RESET_PULSE_MIN_CYC - 1); // R23
                        end
                        default: next_state = S_W_SETUP;
                    endcase
                end
            end
            S_W_SETUP: begin
                next_state = S_W_LOW;
                tmr_load   = 1'b1;
                tmr_val    = TMR_W'(WE_LOW_CYC - 1);
            end
            S_W_LOW: begin
                if (tmr_done) begin
                    next_state = S_W_HOLD;
                    tmr_load   = 1'b1;
                    tmr_val    = TMR_W'(WE_HIGH_CYC - 1);
                end
            end
            S_W_HOLD: begin
                if (tmr_done && !last_step) begin
                    next_state = S_W_SETUP;
                end else if (tmr_done && op == OP_PROG) begin
                    // Extra cycle covers the pin register lag before busy shows
                    next_state = S_BUSY; // R17
                    tmr_load   = 1'b1;
                    tmr_val    = TMR_W'(BUSY_CYC);
                end else if (tmr_done) begin
                    next_state = S_IDLE;
                end
            end
            S_R_ACC: begin
                if (tmr_done) begin
                    next_state = S_R_END;
                    tmr_load   = 1'b1;
                    tmr_val    = TMR_W'(DF_CYC - 1);
                end
            end
            S_R_END:    if (tmr_done) next_state = S_IDLE;
            S_BUSY: begin
                // A failed program never releases busy; timeout hands it to software
                if ((tmr_done && ready_busy_n) || poll_cnt == PW'(PROG_TIMEOUT_CYC))
                    next_state = S_IDLE; // R24 R20
            end
            S_RST_LOW: begin
                if (tmr_done) begin
                    next_state = S_RST_WAIT;
                    tmr_load   = 1'b1;
                    tmr_val    = TMR_W'(READY_CYC - 1); // R15
                end
            end
            S_RST_WAIT: if (tmr_done) next_state = S_IDLE; // R23
            default:    next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= S_IDLE;
            op    <= OP_NONE;
            idx   <= 2'd0;
        end else begin
            state <= next_state;
            if (start) begin
                op  <= start_op;
                idx <= 2'd0;
            end else if (state == S_W_HOLD && tmr_done && !last_step) begin
                idx <= idx + 2'd1;
            end
        end
    end

    // Pins follow the state one cycle late so address and data lead the strobes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            flash_chip_select_n <= 1'b1;
            write_enable_n      <= 1'b1;
            output_enable_n     <= 1'b1;
            flash_reset_n       <= 1'b1;
            dq_oe               <= 1'b0;
            dq_out              <= 16'h0000;
            flash_addr          <= 22'h000000;
            byte_lsb_address    <= 1'b0;
            cmd_cycle           <= 1'b0;
        end else begin
            // Chip select returns high after every read and every command sequence, so each read sees it fall
            flash_chip_select_n <= !(state inside {S_W_SETUP, S_W_LOW, S_W_HOLD, S_R_ACC}); // R03
            write_enable_n      <= (state != S_W_LOW); // R09 R10
            output_enable_n     <= (state != S_R_ACC); // R08
            dq_oe               <= (state inside {S_W_SETUP, S_W_LOW, S_W_HOLD}); // R08
            flash_reset_n       <= (state != S_RST_LOW); // R06 R23
            if (state == S_W_SETUP) begin
                flash_addr       <= step[37:16];
                byte_lsb_address <= (op == OP_PROG && last_step) ? addr_reg[ADDR_LSB_BIT] : 1'b0;
                cmd_cycle        <= !(op == OP_PROG && last_step);
                dq_out           <= (op == OP_PROG && last_step)
                                    ? (flash_width_select ? step[15:0] : {8'h00, step[7:0]})
                                    : {8'h00, step[7:0]}; // R11 R16
            end else if (start && start_op == OP_READ) begin
                flash_addr       <= addr_reg[21:0];
                byte_lsb_address <= flash_width_select ? 1'b0 : addr_reg[ADDR_LSB_BIT]; // R16
            end
        end
    end

    // Software register file
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            addr_reg           <= '0;
            wdata_reg          <= 16'h0000;
            flash_width_select <= WIDTH_RESET;
        end else if (reg_wr && state == S_IDLE) begin
            if (reg_addr == REG_ADDR)  addr_reg  <= reg_wdata[22:0];
            if (reg_addr == REG_WDATA) wdata_reg <= reg_wdata[15:0];
            if (reg_addr == REG_CTRL)  flash_width_select <= reg_wdata[CTRL_WIDTH_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_reg <= 16'h0000;
        end else if (state == S_R_END && tmr_done) begin
            rdata_reg <= flash_width_select ? dq_in : {8'h00, dq_in[7:0]}; // R16
        end
    end

    // Fast mode mirrors the device: only the exit command or a hardware reset ends it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fast_mode <= 1'b0;
        end else if (state == S_W_HOLD && tmr_done && last_step) begin
            if (op == OP_FASTENTER) fast_mode <= 1'b1; // R22
            if (op == OP_FASTEXIT)  fast_mode <= 1'b0; // R22
        end else if (state == S_RST_LOW) begin
            fast_mode <= 1'b0; // R15
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            poll_cnt <= '0;
        end else if (state == S_BUSY) begin
            poll_cnt <= poll_cnt + 1'b1;
        end else begin
            poll_cnt <= '0;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            timeout <= 1'b0;
        end else if (state == S_BUSY && poll_cnt == PW'(PROG_TIMEOUT_CYC)) begin
            timeout <= 1'b1; // R20
        end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_TIMEOUT]) begin
            timeout <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:   reg_rdata <= {27'h0, flash_width_select, 1'b0, op};
                REG_ADDR:   reg_rdata <= {9'h000, addr_reg};
                REG_WDATA:  reg_rdata <= {16'h0000, wdata_reg};
                REG_RDATA:  reg_rdata <= {16'h0000, rdata_reg};
                REG_STATUS: reg_rdata <= {27'h0, flash_width_select, ready_busy_n, timeout,
                                          fast_mode, state != S_IDLE};
                default:    reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    logic [4:0] rst_low_cnt;
    always_ff @(posedge clk_sys) begin
        if (!resetn) rst_low_cnt <= 5'h00;
        else if (!flash_reset_n) rst_low_cnt <= rst_low_cnt + 5'h01;
        else rst_low_cnt <= 5'h00;
    end

    a_strobe_excl: assert property (@(posedge clk_sys) disable iff (!resetn) // R09
        !(!write_enable_n && !output_enable_n)) else $error("write and output strobes overlap");
    a_we_needs_ce: assert property (@(posedge clk_sys) disable iff (!resetn) // R09
        !write_enable_n |-> !flash_chip_select_n && output_enable_n && dq_oe)
        else $error("write strobe without chip select");
    a_cmd_low_byte: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        (!write_enable_n && cmd_cycle) |-> dq_out[15:8] == 8'h00)
        else $error("command data on upper lines");
    a_read_ce_falls: assert property (@(posedge clk_sys) disable iff (!resetn) // R03
        $fell(output_enable_n) |-> $fell(flash_chip_select_n))
        else $error("read without chip select falling");
    a_reset_pulse_len: assert property (@(posedge clk_sys) disable iff (!resetn) // R23
        $rose(flash_reset_n) |-> rst_low_cnt == 5'(RESET_PULSE_MIN_CYC))
        else $error("reset pulse length wrong");
    a_we_pulse_len: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
        $fell(write_enable_n) |=> write_enable_n) else $error("write pulse length wrong");
    a_prog_to_busy: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
        (state == S_W_HOLD && tmr_done && last_step && op == OP_PROG) |=> state == S_BUSY)
        else $error("program did not wait for busy");
    a_busy_release: assert property (@(posedge clk_sys) disable iff (!resetn) // R24
        (state == S_BUSY && tmr_done && ready_busy_n) |=> state == S_IDLE)
        else $error("ready not honoured");
    a_byte_float: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
        (dq_oe && !flash_width_select) |-> dq_out[14:8] == 7'h00)
        else $error("upper lines driven in byte mode");
    a_rst_wait_ready: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
        $rose(flash_reset_n) |-> state == S_RST_WAIT ##1 state == S_RST_WAIT)
        else $error("ready delay skipped");
endmodule : fmc_host

// [rtl/fmc_pkg.sv]
// Shared constants for the flash mode and command host controller.
// Assumes a 20 MHz system clock; all pin timing is derived from it here.
package fmc_pkg;
    localparam int CLK_PERIOD_NS = 50;

    // Least time in cycles, rounded up, never below one cycle
    function automatic int fmc_min_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : fmc_min_cyc

    localparam int WE_LOW_NS    = 50;
    localparam int WE_HIGH_NS   = 20;
    localparam int ACC_NS       = 90;
    localparam int DF_NS        = 30;
    localparam int BUSY_NS      = 90;
    localparam int RESET_PULSE_MIN_NS = 500;
    localparam int READY_US     = 20;
    localparam int PROG_MAX_US  = 300;

    localparam int WE_LOW_CYC   = fmc_min_cyc(WE_LOW_NS);
    localparam int WE_HIGH_CYC  = fmc_min_cyc(WE_HIGH_NS);
    localparam int ACC_CYC      = fmc_min_cyc(ACC_NS);
    localparam int DF_CYC       = fmc_min_cyc(DF_NS);
    localparam int BUSY_CYC     = fmc_min_cyc(BUSY_NS);
    localparam int RESET_PULSE_MIN_CYC = fmc_min_cyc(RESET_PULSE_MIN_NS);
    localparam int READY_CYC    = fmc_min_cyc(READY_US * 1000);
    localparam int PROG_MAX_CYC = fmc_min_cyc(PROG_MAX_US * 1000);

    localparam int TMR_W = 16;

    // Register map of the controller
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_RDATA  = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;

    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_WIDTH_BIT = 4;
    localparam int ST_BUSY        = 0;
    localparam int ST_FAST        = 1;
    localparam int ST_TIMEOUT     = 2;
    localparam int ST_READY       = 3;
    localparam int ST_WIDTH       = 4;
    localparam int ADDR_LSB_BIT   = 22;
    localparam logic WIDTH_RESET  = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE, OP_READ, OP_PROG, OP_IDREAD,
        OP_SWRESET, OP_FASTENTER, OP_FASTEXIT, OP_HWRESET
    } fmc_op_t;

    // Command bytes and unlock addresses
    localparam logic [7:0]  CMD_UNLOCK1   = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
    localparam logic [7:0]  CMD_PROG      = 8'ha0;
    localparam logic [7:0]  CMD_IDREAD    = 8'h90;
    localparam logic [7:0]  CMD_RESET     = 8'hf0;
    localparam logic [7:0]  CMD_FAST      = 8'h20;
    localparam logic [7:0]  CMD_FAST_EXIT = 8'h90;
    localparam logic [21:0] ADDR_UNLOCK1  = 22'h000555;
    localparam logic [21:0] ADDR_UNLOCK2  = 22'h0002aa;
    localparam int          BANK_LSB      = 15;
endpackage : fmc_pkg

// [rtl/fmc_timer.sv]
// Down counter shared by all timed phases of the controller.
// Assumes load is a one-cycle pulse from the owning state machine.
`timescale 1ns/1ps
module fmc_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    logic [W-1:0] count;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done = (count == '0);
endmodule : fmc_timer
